//--- dv/lhpirq_checker.sv
`timescale 1ns/1ps
module lhpirq_checker
  import lhpirq_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       iface_mode_pin,
  input wire logic       serial_sel_pin,
  input wire logic       bus_style_pin,
  input wire logic       addr_data_share_pin,
  input wire logic       clock_edge_sel,
  input wire logic       chip_sel_n,
  input wire logic       rd_strobe_n,
  input wire logic       wr_strobe_n,
  input wire logic       data_strobe_n,
  input wire logic       rd_wr_sel,
  input wire logic       addr_strobe_n,
  input wire logic       addr_latch,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] d_in,
  input wire logic [7:0] d_out,
  input wire logic       d_oe_n,
  input wire logic       ack_n,
  input wire logic       ready,
  input wire logic       sclk,
  input wire logic       serial_in,
  input wire logic       serial_out,
  input wire logic       serial_out_oe_n,
  input wire logic [7:0] signal_loss,
  input wire logic [7:0] driver_fault,
  input wire logic [7:0] alarm_signal,
  input wire logic       irq_out_n,
  input wire logic       irq_oe_n,
  input wire logic [7:0] send_all_ones_enable,
  input wire logic [7:0] line_output_disable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_ANSWER_NEEDS_SELECT: assert property ((!ack_n || ready) |-> !$past(chip_sel_n, 3) && $past(iface_mode_pin, 3))
    else $error("answer without chip select in parallel mode");
  AST_ACK_STROBE_STYLE: assert property (!ack_n |-> !$past(bus_style_pin, 3))
    else $error("acknowledge in read/write strobe style");
  AST_READY_RDWR_STYLE: assert property (ready |-> $past(bus_style_pin, 3))
    else $error("ready in data strobe style");
  AST_READ_DATA_STROBE: assert property ((!d_oe_n && !ack_n) |-> $past(rd_wr_sel, 3))
    else $error("data bus driven on a write");
  AST_READ_DATA_RDWR: assert property ((!d_oe_n && ready) |-> !$past(rd_strobe_n, 3))
    else $error("data bus driven without read strobe");
  AST_ANSWER_STANDS: assert property ($fell(ack_n) |-> (!ack_n) [*3])
    else $error("acknowledge dropped early");
  AST_ANSWER_RELEASED: assert property ($rose(chip_sel_n) |-> ##[1:4] (ack_n && !ready && d_oe_n))
    else $error("answer not released after deselect");
  AST_IRQ_RELEASE_BY_HOST: assert property ($rose(irq_oe_n) |-> !$past(chip_sel_n, 2) || !$past(chip_sel_n, 3)
    || !$past(chip_sel_n, 4) || !$past(chip_sel_n, 5))
    else $error("interrupt released without host access");
  AST_CONFIG_BY_WRITE: assert property ($changed(send_all_ones_enable) |-> !$past(chip_sel_n, 2)
    || !$past(chip_sel_n, 3) || !$past(chip_sel_n, 4))
    else $error("configuration changed without host access");

  cover property ($fell(ack_n));
  cover property ($rose(ready));
  cover property ($rose(irq_oe_n));
endmodule  // lhpirq_checker

bind lhpirq_regbank lhpirq_checker u_lhpirq_checker (.*);

//--- dv/lhpirq_host_model.sv
`timescale 1ns/1ps
module lhpirq_host_model
  import lhpirq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       bus_style_pin,
  input  wire logic       addr_data_share_pin,
  input  wire logic       ack_n,
  input  wire logic       ready,
  input  wire logic       serial_out,
  output logic            sclk,
  output logic            serial_in,
  output logic            chip_sel_n,
  output logic            rd_strobe_n,
  output logic            wr_strobe_n,
  output logic            data_strobe_n,
  output logic            rd_wr_sel,
  output logic            addr_strobe_n,
  output logic            addr_latch,
  output logic      [4:0] addr_in,
  output logic      [7:0] d_in
);
  initial begin
    chip_sel_n    = 1'b1;
    rd_strobe_n   = 1'b1;
    wr_strobe_n   = 1'b1;
    data_strobe_n = 1'b1;
    rd_wr_sel     = 1'b1;
    addr_strobe_n = 1'b1;
    addr_latch    = 1'b1;
    addr_in       = 5'h00;
    d_in          = 8'h00;
    sclk          = 1'b0;
    serial_in     = 1'b0;
  end

  // Serial access: command byte then data byte, LSB first; read bits are taken late in each high phase.
  task automatic ser(input logic rdf, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] w;
    w = {wd, 2'b00, a, rdf};
    q = 8'h00;
    @(posedge clock);
    #1;
    chip_sel_n = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    for (int i = 0; i < 16; i++) begin
      sclk      = 1'b0;
      serial_in = w[i];
      repeat (4) @(posedge clock);
      #1;
      sclk = 1'b1;
      repeat (4) @(posedge clock);
      if (i > 7) q[i-8] = serial_out;
      #1;
    end
    chip_sel_n = 1'b1;
    sclk       = 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // A bounded wait lets a refused access return with ok low instead of hanging.
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] wd, output logic ok);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    chip_sel_n = 1'b0;
    rd_wr_sel  = rd;
    addr_in    = a[4:0];
    if (addr_data_share_pin) begin
      d_in          = a;
      addr_latch    = bus_style_pin;
      addr_strobe_n = bus_style_pin;
      repeat (3) @(posedge clock);
      #1;
      addr_latch    = 1'b0;
      addr_strobe_n = 1'b1;
    end
    d_in          = rd ? ~d_in : wd;
    rd_strobe_n   = !(bus_style_pin && rd);
    wr_strobe_n   = !(bus_style_pin && !rd);
    data_strobe_n = bus_style_pin;
    do begin
      @(posedge clock);
      n++;
      ok = (ack_n === 1'b0) || (ready === 1'b1);
    end while (!ok && n < 12);
    #1;
    chip_sel_n    = 1'b1;
    rd_strobe_n   = 1'b1;
    wr_strobe_n   = 1'b1;
    data_strobe_n = 1'b1;
    d_in          = ~d_in;
    addr_in       = ~addr_in;
    repeat (4) @(posedge clock);
    #1;
  endtask
endmodule  // lhpirq_host_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import lhpirq_pkg::*;
  localparam logic [7:0] IDENT = 8'h3c;  // Arbitrary identity value.
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        iface_mode_pin = 1'b1, serial_sel_pin = 1'b0, bus_style_pin = 1'b0, addr_data_share_pin = 1'b0;
  logic        clock_edge_sel = 1'b0, sclk, serial_in;
  logic        chip_sel_n, rd_strobe_n, wr_strobe_n, data_strobe_n, rd_wr_sel, addr_strobe_n, addr_latch;
  logic        d_oe_n, ack_n, ready, serial_out, serial_out_oe_n, irq_out_n, irq_oe_n, ok, ans, ans_d = 1'b0;
  logic [4:0]  addr_in;
  logic [7:0]  d_in, d_out, send_all_ones_enable, line_output_disable, r, b;
  logic [7:0]  signal_loss = 8'h00, driver_fault = 8'h00, alarm_signal = 8'h00;
  logic [7:0]  expq[$];
  logic [7:0]  rw_ofs[14] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11,
                              8'h12, 8'h14};
  logic [7:0]  ie_ofs[3] = '{8'h06, 8'h07, 8'h14};
  logic [7:0]  is_ofs[3] = '{8'h08, 8'h09, 8'h15};
  logic [7:0]  lv_ofs[3] = '{8'h04, 8'h05, 8'h13};
  logic [7:0]  banks[2] = '{8'haa, 8'h02};
  logic [31:0] seed = 32'h0000_c53a;
  int          miscompares = 0;
  int          n_tests = 0;
  // The board pull-up holds the pin high whenever the device lets go of it.
  wire         irq_pin = irq_oe_n ? 1'b1 : irq_out_n;

  always #5 clock = ~clock;

  lhpirq_regbank #(.IDENT_VALUE(IDENT)) u_lhpirq_regbank (.*);
  lhpirq_host_model u_lhpirq_host_model (.*);

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Upper address bits are random so that aliasing is exercised on the shared bus.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] u;
    u = rnd();
    u_lhpirq_host_model.acc(1'b0, {u[7:5], a[4:0]}, v, ok);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] u;
    u = rnd();
    expq.push_back(e);
    u_lhpirq_host_model.acc(1'b1, {u[7:5], a[4:0]}, 8'h00, ok);
  endtask

  task automatic irq_wait(input logic lvl);
    int n;
    n = 0;
    while (irq_pin !== lvl && n < 20) begin
      @(posedge clock);
      n++;
    end
    #1;
    check({7'h00, irq_pin}, {7'h00, lvl});
  endtask

  task automatic set_live(input int k, input logic [7:0] v);
    case (k)
      0: signal_loss = v;
      1: driver_fault = v;
      default: alarm_signal = v;
    endcase
  endtask

  always @(negedge clock) begin
    ans = (d_oe_n === 1'b0) && ((ack_n === 1'b0) || (ready === 1'b1));
    if (ans && !ans_d) check(d_out, (expq.size() != 0) ? expq.pop_front() : ~d_out);
    ans_d = ans;
  end

  initial begin
    repeat (4) @(posedge clock);
    #1;
    reset_n = 1'b1;
    rd(8'h1f, 8'h00);
    rd(8'h00, IDENT);
    for (int m = 0; m < 2; m++) begin
      bus_style_pin       = m[0];
      addr_data_share_pin = m[0];
      foreach (rw_ofs[i]) begin
        r = rnd();
        wr(rw_ofs[i], r);
        rd(rw_ofs[i], r);
        if (rw_ofs[i] == 8'h03) check(send_all_ones_enable, r);
        if (rw_ofs[i] == 8'h12) check(line_output_disable, r);
      end
      wr(8'h16, rnd());
      rd(8'h16, 8'h00);
      $display("register test in mode %0d done", m);
    end
    iface_mode_pin = 1'b0;
    u_lhpirq_host_model.acc(1'b1, 8'h00, 8'h00, ok);
    check({7'h00, ok}, 8'h00);
    serial_sel_pin = 1'b1;
    for (int m = 0; m < 2; m++) begin
      clock_edge_sel = m[0];
      r = rnd();
      u_lhpirq_host_model.ser(1'b0, 5'h01, r, b);
      u_lhpirq_host_model.ser(1'b1, 5'h01, 8'h00, b);
      check(b, r);
    end
    $display("serial test done");
    serial_sel_pin = 1'b0;
    iface_mode_pin = 1'b1;
    foreach (banks[i]) begin
      wr(8'h1f, banks[i]);
      rd(8'h1f, banks[i]);
      rd(8'h00, 8'h00);
    end
    wr(8'h1f, 8'h00);
    rd(8'h00, IDENT);
    $display("bank test done");
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      b = 8'h01 << r[2:0];
      wr(ie_ofs[k], 8'h00);
      set_live(k, b);
      rd(lv_ofs[k], b);
      check({7'h00, irq_pin}, 8'h01);
      wr(ie_ofs[k], 8'hff);
      irq_wait(1'b0);
      rd(is_ofs[k], b);
      irq_wait(1'b1);
      check({7'h00, irq_oe_n}, 8'h01);
      rd(is_ofs[k], 8'h00);
    end
    $display("clear on read test done");
    wr(8'h1f, 8'h01);
    wr(8'h1e, 8'h03);
    rd(8'h1e, 8'h03);
    wr(8'h1f, 8'h00);
    irq_wait(1'b1);
    check({7'h00, irq_oe_n}, 8'h00);
    r = signal_loss;
    set_live(0, 8'h00);
    irq_wait(1'b0);
    rd(8'h08, r);
    rd(8'h08, r);
    wr(8'h08, ~r);
    rd(8'h08, r);
    wr(8'h08, r);
    irq_wait(1'b1);
    rd(8'h08, 8'h00);
    $display("clear by write test done");
    print_verdict();
  end

  initial begin
    #100us;
    miscompares++;
    print_verdict();
  end
endmodule  // tb_top

//--- rtl/lhpirq_map.svh
`ifndef LHPIRQ_MAP_SVH
`define LHPIRQ_MAP_SVH

// Primary bank offsets; the global interrupt control register is in the individual bank.
`define LHPIRQ_OFS_IDENT       5'h00
`define LHPIRQ_OFS_ALB_CFG     5'h01
`define LHPIRQ_OFS_RLB_CFG     5'h02
`define LHPIRQ_OFS_ALL_ONES    5'h03
`define LHPIRQ_OFS_LOSS_ST     5'h04
`define LHPIRQ_OFS_DFLT_ST     5'h05
`define LHPIRQ_OFS_LOSS_IE     5'h06
`define LHPIRQ_OFS_DFLT_IE     5'h07
`define LHPIRQ_OFS_LOSS_IS     5'h08
`define LHPIRQ_OFS_DFLT_IS     5'h09
`define LHPIRQ_OFS_SOFT_RST    5'h0a
`define LHPIRQ_OFS_MON_CTRL    5'h0b
`define LHPIRQ_OFS_DLB_CFG     5'h0c
`define LHPIRQ_OFS_CRITERIA    5'h0d
`define LHPIRQ_OFS_AUTO_ONES   5'h0e
`define LHPIRQ_OFS_GLOBAL_CFG  5'h0f
`define LHPIRQ_OFS_SHAPE_UNIT  5'h10
`define LHPIRQ_OFS_SHAPE_SEL   5'h11
`define LHPIRQ_OFS_OUT_DIS     5'h12
`define LHPIRQ_OFS_AIS_ST      5'h13
`define LHPIRQ_OFS_AIS_IE      5'h14
`define LHPIRQ_OFS_AIS_IS      5'h15
`define LHPIRQ_OFS_GIRQ_CTRL   5'h1e
`define LHPIRQ_OFS_BANK_PTR    5'h1f

// Bank pointer codes.
`define LHPIRQ_BANK_PRIMARY    8'h00
`define LHPIRQ_BANK_INDIV      8'h01
`define LHPIRQ_BANK_PATTERN    8'h02
`define LHPIRQ_BANK_SECOND     8'haa

// Field positions in the global interrupt control register.
`define LHPIRQ_GIC_PIN_DRIVE   0
`define LHPIRQ_GIC_CLR_WRITE   1

// Serial command byte layout, first bit received is bit 0.
`define LHPIRQ_CMD_READ        0
`define LHPIRQ_CMD_ADDR_LO     1
`define LHPIRQ_CMD_ADDR_HI     5
`define LHPIRQ_BIT_LAST        3'h7

// Reset values.
`define LHPIRQ_RST_BYTE        8'h00
`define LHPIRQ_RST_ADDR        5'h00
`define LHPIRQ_RST_CNT         3'h0

`endif

//--- rtl/lhpirq_pkg.sv
package lhpirq_pkg;

  typedef enum logic [2:0] {
    LHPIRQ_IDLE  = 3'b000,
    LHPIRQ_PAR   = 3'b001,
    LHPIRQ_SCMD  = 3'b011,
    LHPIRQ_SDATA = 3'b010,
    LHPIRQ_SWAIT = 3'b110
  } lhpirq_state_t;

  typedef struct packed {
    logic       iface_mode_pin;
    logic       serial_sel_pin;
    logic       bus_style_pin;
    logic       addr_data_share_pin;
    logic       clock_edge_sel;
    logic       chip_sel_n;
    logic       rd_strobe_n;
    logic       wr_strobe_n;
    logic       data_strobe_n;
    logic       rd_wr_sel;
    logic       addr_strobe_n;
    logic       addr_latch;
    logic       sclk;
    logic       serial_in;
    logic [4:0] addr_in;
    logic [7:0] d_in;
  } lhpirq_pins_t;

  typedef struct packed {
    lhpirq_state_t   st;
    lhpirq_pins_t    meta;
    lhpirq_pins_t    sync;
    logic            sclk_d;
    logic [31:0][7:0] regs;
    logic [7:0]      bank;
    logic [7:0]      gic;
    logic [2:0][7:0] irq_st;
    logic [2:0][7:0] prev_live;
    logic [4:0]      addr;
    logic [4:0]      latched_addr;
    logic [7:0]      shreg;
    logic [2:0]      bitcnt;
    logic            is_read;
    logic [7:0]      d_out;
    logic            d_oe_n;
    logic            ack_n;
    logic            ready;
    logic            serial_out;
    logic            serial_out_oe_n;
    logic            irq_out_n;
    logic            irq_oe_n;
  } lhpirq_regs_t;

endpackage

//--- rtl/lhpirq_regbank.sv
// Notes on behaviour
// - Address and data shared or on separate buses.
// - Bus style pin high selects read/write strobes.
// - Parallel port works only with mode pin high.
// - Mode 100: data strobe, acknowledge, separate buses.
// - Mode 111: read/write strobes, ready, shared bus.
// - Interrupt pin open drain unless drive bit set.
// - Three interrupt sources per channel.
// - Live status change sets interrupt status bit.
// - Enabled pending status bit pulls interrupt low.
// - Clear-on-read mode: reading status clears it.
// - Clear-by-write mode: writing one clears bit.
// - Live status registers readable independently.
// - Five address bits, parallel or serial command.
// - Per-channel registers hold one bit per channel.
// - Bank pointer selects individual bank; secondary and pattern codes read zero.
// - Reset returns bank pointer to primary bank.
// - Serial command byte LSB first, read flag first.
`timescale 1ns/1ps
`include "lhpirq_map.svh"

module lhpirq_regbank
  import lhpirq_pkg::*;
#(
  parameter logic [7:0] IDENT_VALUE = 8'h5a  // Arbitrary identity value.
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       iface_mode_pin,
  input  wire logic       serial_sel_pin,
  input  wire logic       bus_style_pin,
  input  wire logic       addr_data_share_pin,
  input  wire logic       clock_edge_sel,
  input  wire logic       chip_sel_n,
  input  wire logic       rd_strobe_n,
  input  wire logic       wr_strobe_n,
  input  wire logic       data_strobe_n,
  input  wire logic       rd_wr_sel,
  input  wire logic       addr_strobe_n,
  input  wire logic       addr_latch,
  input  wire logic [4:0] addr_in,
  input  wire logic [7:0] d_in,
  output logic      [7:0] d_out,
  output logic            d_oe_n,
  output logic            ack_n,
  output logic            ready,
  input  wire logic       sclk,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe_n,
  input  wire logic [7:0] signal_loss,
  input  wire logic [7:0] driver_fault,
  input  wire logic [7:0] alarm_signal,
  output logic            irq_out_n,
  output logic            irq_oe_n,
  output logic      [7:0] send_all_ones_enable,
  output logic      [7:0] line_output_disable
);

  localparam logic [2:0][4:0] IRQ_STS_OFS = {`LHPIRQ_OFS_AIS_IS, `LHPIRQ_OFS_DFLT_IS, `LHPIRQ_OFS_LOSS_IS};
  localparam logic [2:0][4:0] IRQ_ENA_OFS = {`LHPIRQ_OFS_AIS_IE, `LHPIRQ_OFS_DFLT_IE, `LHPIRQ_OFS_LOSS_IE};

  lhpirq_regs_t    s;
  lhpirq_regs_t    next_s;
  lhpirq_pins_t    pins_raw;
  logic [2:0][7:0] live;

  assign pins_raw = '{
    iface_mode_pin:      iface_mode_pin,
    serial_sel_pin:      serial_sel_pin,
    bus_style_pin:       bus_style_pin,
    addr_data_share_pin: addr_data_share_pin,
    clock_edge_sel:      clock_edge_sel,
    chip_sel_n:          chip_sel_n,
    rd_strobe_n:         rd_strobe_n,
    wr_strobe_n:         wr_strobe_n,
    data_strobe_n:       data_strobe_n,
    rd_wr_sel:           rd_wr_sel,
    addr_strobe_n:       addr_strobe_n,
    addr_latch:          addr_latch,
    sclk:                sclk,
    serial_in:           serial_in,
    addr_in:             addr_in,
    d_in:                d_in
  };

  // Live status comes from line logic on this clock, so it is not resynchronised.
  assign live = {alarm_signal, driver_fault, signal_loss};

  // Offsets that hold plain read/write storage in the primary bank.
  function automatic logic is_storage(input logic [4:0] a);
    case (a)
      `LHPIRQ_OFS_ALB_CFG, `LHPIRQ_OFS_RLB_CFG, `LHPIRQ_OFS_ALL_ONES,
      `LHPIRQ_OFS_LOSS_IE, `LHPIRQ_OFS_DFLT_IE, `LHPIRQ_OFS_MON_CTRL,
      `LHPIRQ_OFS_DLB_CFG, `LHPIRQ_OFS_CRITERIA, `LHPIRQ_OFS_AUTO_ONES,
      `LHPIRQ_OFS_GLOBAL_CFG, `LHPIRQ_OFS_SHAPE_UNIT, `LHPIRQ_OFS_SHAPE_SEL,
      `LHPIRQ_OFS_OUT_DIS, `LHPIRQ_OFS_AIS_IE: is_storage = 1'b1;
      default:                                 is_storage = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] read_reg(input lhpirq_regs_t r, input logic [4:0] a,
                                          input logic [2:0][7:0] lv);
    read_reg = `LHPIRQ_RST_BYTE;
    if (a == `LHPIRQ_OFS_BANK_PTR) begin
      read_reg = r.bank;
    end else if (r.bank == `LHPIRQ_BANK_INDIV) begin
      if (a == `LHPIRQ_OFS_GIRQ_CTRL) begin
        read_reg = r.gic;
      end
    end else if (r.bank == `LHPIRQ_BANK_PRIMARY) begin
      case (a)
        `LHPIRQ_OFS_IDENT:   read_reg = IDENT_VALUE;
        `LHPIRQ_OFS_LOSS_ST: read_reg = lv[0];
        `LHPIRQ_OFS_DFLT_ST: read_reg = lv[1];
        `LHPIRQ_OFS_AIS_ST:  read_reg = lv[2];
        `LHPIRQ_OFS_LOSS_IS: read_reg = r.irq_st[0];
        `LHPIRQ_OFS_DFLT_IS: read_reg = r.irq_st[1];
        `LHPIRQ_OFS_AIS_IS:  read_reg = r.irq_st[2];
        default: begin
          if (is_storage(a)) begin
            read_reg = r.regs[a];
          end else begin
            read_reg = `LHPIRQ_RST_BYTE;
          end
        end
      endcase
    end
  endfunction

  always_comb begin
    logic       par_mode;
    logic       ser_mode;
    logic       rw_style;
    logic       p_rd;
    logic       p_wr;
    logic       rise;
    logic       fall;
    logic       out_edge;
    logic       rd_en;
    logic       wr_en;
    logic [4:0] acc_addr;
    logic [7:0] wr_data;
    logic [7:0] byte_in;
    logic [7:0] rd_val;
    logic       primary;
    logic       clr_write;
    logic [7:0] clr;
    logic       pending;
    next_s    = s;
    rd_en     = 1'b0;
    wr_en     = 1'b0;
    acc_addr  = s.addr;
    wr_data   = s.sync.d_in;
    byte_in   = {s.sync.serial_in, s.shreg[7:1]};
    rd_val    = `LHPIRQ_RST_BYTE;
    clr       = `LHPIRQ_RST_BYTE;
    pending   = 1'b0;

    next_s.meta   = pins_raw;
    next_s.sync   = s.meta;
    next_s.sclk_d = s.sync.sclk;

    par_mode = s.sync.iface_mode_pin;
    ser_mode = ~s.sync.iface_mode_pin & s.sync.serial_sel_pin;
    rw_style = s.sync.bus_style_pin;
    p_rd     = rw_style ? ~s.sync.rd_strobe_n : (~s.sync.data_strobe_n & s.sync.rd_wr_sel);
    p_wr     = rw_style ? ~s.sync.wr_strobe_n : (~s.sync.data_strobe_n & ~s.sync.rd_wr_sel);
    rise     = s.sync.sclk & ~s.sclk_d;
    fall     = ~s.sync.sclk & s.sclk_d;
    out_edge = s.sync.clock_edge_sel ? fall : rise;

    // Only the low five lines carry the address; the rest alias.
    if (par_mode && s.sync.addr_data_share_pin) begin
      if (rw_style ? s.sync.addr_latch : (~s.sync.addr_strobe_n & s.sync.data_strobe_n)) begin
        next_s.latched_addr = s.sync.d_in[4:0];
      end
    end

    case (s.st)
      LHPIRQ_IDLE: begin
        next_s.bitcnt = `LHPIRQ_RST_CNT;
        if (par_mode && !s.sync.chip_sel_n && (p_rd || p_wr)) begin
          acc_addr      = s.sync.addr_data_share_pin ? s.latched_addr : s.sync.addr_in;
          next_s.addr   = acc_addr;
          rd_en         = p_rd;
          wr_en         = p_wr;
          rd_val        = read_reg(s, acc_addr, live);
          next_s.d_out  = p_rd ? rd_val : `LHPIRQ_RST_BYTE;
          next_s.d_oe_n = ~p_rd;
          next_s.ack_n  = rw_style;
          next_s.ready  = rw_style;
          next_s.st     = LHPIRQ_PAR;
        end else if (ser_mode && !s.sync.chip_sel_n) begin
          next_s.st = LHPIRQ_SCMD;
        end
      end
      LHPIRQ_PAR: begin
        // Held until the strobe or chip select goes away so a slow host sees a stable answer.
        if (s.sync.chip_sel_n || !(p_rd || p_wr) || !par_mode) begin
          next_s.d_oe_n = 1'b1;
          next_s.ack_n  = 1'b1;
          next_s.ready  = 1'b0;
          next_s.st     = LHPIRQ_IDLE;
        end
      end
      LHPIRQ_SCMD: begin
        if (s.sync.chip_sel_n || !ser_mode) begin
          next_s.st = LHPIRQ_IDLE;
        end else if (rise) begin
          next_s.shreg  = byte_in;
          next_s.bitcnt = s.bitcnt + 3'h1;
          if (s.bitcnt == `LHPIRQ_BIT_LAST) begin
            acc_addr       = byte_in[`LHPIRQ_CMD_ADDR_HI:`LHPIRQ_CMD_ADDR_LO];
            next_s.addr    = acc_addr;
            next_s.is_read = byte_in[`LHPIRQ_CMD_READ];
            next_s.st      = LHPIRQ_SDATA;
            if (byte_in[`LHPIRQ_CMD_READ]) begin
              rd_en                  = 1'b1;
              rd_val                 = read_reg(s, acc_addr, live);
              next_s.serial_out_oe_n = 1'b0;
              next_s.shreg           = rd_val;
              // With rising-edge output the first data bit leaves on this same edge.
              if (!s.sync.clock_edge_sel) begin
                next_s.serial_out = rd_val[0];
                next_s.shreg      = {1'b0, rd_val[7:1]};
              end
            end
          end
        end
      end
      LHPIRQ_SDATA: begin
        if (s.sync.chip_sel_n || !ser_mode) begin
          next_s.serial_out_oe_n = 1'b1;
          next_s.st              = LHPIRQ_IDLE;
        end else if (s.is_read) begin
          if (out_edge && !(s.bitcnt == `LHPIRQ_RST_CNT && rise && !s.sync.clock_edge_sel)) begin
            next_s.serial_out = s.shreg[0];
            next_s.shreg      = {1'b0, s.shreg[7:1]};
          end
          if (rise) begin
            next_s.bitcnt = s.bitcnt + 3'h1;
            if (s.bitcnt == `LHPIRQ_BIT_LAST) begin
              next_s.st = LHPIRQ_SWAIT;
            end
          end
        end else if (rise) begin
          next_s.shreg  = byte_in;
          next_s.bitcnt = s.bitcnt + 3'h1;
          if (s.bitcnt == `LHPIRQ_BIT_LAST) begin
            wr_en     = 1'b1;
            wr_data   = byte_in;
            next_s.st = LHPIRQ_SWAIT;
          end
        end
      end
      LHPIRQ_SWAIT: begin
        // Extra clocks after the data byte only drive serial_out low on a read, until deselect.
        if (s.sync.chip_sel_n || !ser_mode) begin
          next_s.serial_out_oe_n = 1'b1;
          next_s.st              = LHPIRQ_IDLE;
        end else if (s.is_read && out_edge) begin
          next_s.serial_out = 1'b0;
        end
      end
      default: begin
        next_s.st = LHPIRQ_IDLE;
      end
    endcase

    primary   = (s.bank == `LHPIRQ_BANK_PRIMARY);
    clr_write = s.gic[`LHPIRQ_GIC_CLR_WRITE];

    if (wr_en) begin
      if (acc_addr == `LHPIRQ_OFS_BANK_PTR) begin
        next_s.bank = wr_data;
      end else if (s.bank == `LHPIRQ_BANK_INDIV && acc_addr == `LHPIRQ_OFS_GIRQ_CTRL) begin
        next_s.gic = wr_data;
      end else if (primary && is_storage(acc_addr)) begin
        next_s.regs[acc_addr] = wr_data;
      end
    end

    // Clears are applied first so a change seen in the same cycle still sets the bit.
    for (int k = 0; k < 3; k++) begin
      clr = `LHPIRQ_RST_BYTE;
      if (primary && acc_addr == IRQ_STS_OFS[k]) begin
        if (rd_en && !clr_write) begin
          clr = 8'hff;
        end else if (wr_en && clr_write) begin
          clr = wr_data;
        end
      end
      next_s.irq_st[k]    = (s.irq_st[k] & ~clr) | (live[k] ^ s.prev_live[k]);
      next_s.prev_live[k] = live[k];
    end

    if (wr_en && primary && acc_addr == `LHPIRQ_OFS_SOFT_RST) begin
      next_s.regs   = '0;
      next_s.gic    = `LHPIRQ_RST_BYTE;
      next_s.bank   = `LHPIRQ_BANK_PRIMARY;
      for (int k = 0; k < 3; k++) begin
        next_s.irq_st[k] = live[k] ^ s.prev_live[k];
      end
    end

    for (int k = 0; k < 3; k++) begin
      pending = pending | (|(next_s.irq_st[k] & next_s.regs[IRQ_ENA_OFS[k]]));
    end
    if (next_s.gic[`LHPIRQ_GIC_PIN_DRIVE]) begin
      next_s.irq_out_n = ~pending;
      next_s.irq_oe_n  = 1'b0;
    end else begin
      next_s.irq_out_n = 1'b0;
      next_s.irq_oe_n  = ~pending;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s                 <= '0;
      s.st              <= LHPIRQ_IDLE;
      s.bank            <= `LHPIRQ_BANK_PRIMARY;
      s.d_oe_n          <= 1'b1;
      s.ack_n           <= 1'b1;
      s.serial_out_oe_n <= 1'b1;
      s.irq_oe_n        <= 1'b1;
      s.meta.chip_sel_n <= 1'b1;
      s.sync.chip_sel_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign d_out                = s.d_out;
  assign d_oe_n               = s.d_oe_n;
  assign ack_n                = s.ack_n;
  assign ready                = s.ready;
  assign serial_out           = s.serial_out;
  assign serial_out_oe_n      = s.serial_out_oe_n;
  assign irq_out_n            = s.irq_out_n;
  assign irq_oe_n             = s.irq_oe_n;
  assign send_all_ones_enable = s.regs[`LHPIRQ_OFS_ALL_ONES];
  assign line_output_disable  = s.regs[`LHPIRQ_OFS_OUT_DIS];

endmodule // lhpirq_regbank
